// ==== design/vecirq_map.vh ====
// Register offsets, field positions and reset values of the vectored interrupt unit.
`ifndef VECIRQ_MAP_VH
`define VECIRQ_MAP_VH

// ****************************************************************
// Register byte offsets and slot page numbers
// ****************************************************************
`define VIU_OFF_NORMAL_STATUS 12'h000
`define VIU_OFF_FAST_STATUS 12'h004
`define VIU_OFF_RAW_VIEW 12'h008
`define VIU_OFF_CLASS_SELECT 12'h00C
`define VIU_OFF_ENABLE_SET 12'h010
`define VIU_OFF_ENABLE_CLEAR 12'h014
`define VIU_OFF_SOFT_REQUEST 12'h018
`define VIU_OFF_SOFT_CLEAR 12'h01C
`define VIU_OFF_PRIV_ONLY 12'h020
`define VIU_OFF_ACTIVE_VECTOR 12'h030
`define VIU_OFF_DEFAULT_VECTOR 12'h034
`define VIU_OFF_EVENT_STATUS 12'h040
`define VIU_OFF_EVENT_MASK 12'h044
`define VIU_PAGE_SLOT_ADDR 4'h1
`define VIU_PAGE_SLOT_CTRL 4'h2

// ****************************************************************
// Address fields
// ****************************************************************
`define VIU_PAGE_HI 11
`define VIU_PAGE_LO 8
`define VIU_SLOT_HI 5
`define VIU_SLOT_LO 2
`define VIU_SLOT_PAD_HI 7
`define VIU_SLOT_PAD_LO 6
`define VIU_WORD_LO_HI 1

// ****************************************************************
// Slot control fields
// ****************************************************************
`define VIU_CTL_SRC_HI 4
`define VIU_CTL_SRC_LO 0
`define VIU_CTL_INUSE 5
`define VIU_CTL_W 6

// ****************************************************************
// Event bits
// ****************************************************************
`define VIU_EV_FAST 0
`define VIU_EV_NORMAL 1
`define VIU_EV_PRIV 2
`define VIU_EV_W 3

// ****************************************************************
// Bus constants and reset values
// ****************************************************************
`define VIU_RESP_OKAY 2'h0
`define VIU_RESP_SLVERR 2'h2
`define VIU_STRB_FULL 4'hF
`define VIU_RST_WORD 32'h0000_0000
`define VIU_RST_CTL 6'h00
`define VIU_RST_EV 3'h0

`endif

// ==== design/viu_vectored_irq_unit.v ====
// Vectored interrupt unit with an AXI4-Lite register slave.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "vecirq_map.vh"

module viu_vectored_irq_unit #(
    parameter NUM_REQ = 32,
    parameter NUM_SLOT = 16,
    parameter ADDR_W = 12
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Interrupt sources and outputs
    input wire [NUM_REQ-1:0] hw_request,
    output wire fast_irq_out,
    output wire normal_irq_out,
    output wire irq_out,
    // AXI4-Lite write address channel
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response channel
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address channel
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data channel
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    // ****************************************************************
    // Configuration and state
    // ****************************************************************
    reg [NUM_REQ-1:0] class_select_r;
    reg [NUM_REQ-1:0] enable_r;
    reg [NUM_REQ-1:0] soft_request_word_r;
    reg privileged_only_flag_r;
    reg [31:0] default_vector_word_r;
    reg [31:0] slot_addr_r [0:NUM_SLOT-1];
    reg [`VIU_CTL_W-1:0] slot_ctl_r [0:NUM_SLOT-1];
    reg [`VIU_EV_W-1:0] event_status_r;
    reg [`VIU_EV_W-1:0] event_mask_r;
    reg fast_prev_r;
    reg normal_prev_r;

    // AXI slave state
    reg aw_held_r;
    reg [ADDR_W-1:0] aw_addr_r;
    reg aw_priv_r;
    reg w_held_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg bvalid_r;
    reg [1:0] bresp_r;
    reg rvalid_r;
    reg [31:0] rdata_r;
    reg [1:0] rresp_r;

    // ****************************************************************
    // Request classification
    // ****************************************************************
    wire [NUM_REQ-1:0] raw_request_view;
    wire [NUM_REQ-1:0] fast_class_status;
    wire [NUM_REQ-1:0] normal_class_status;

    assign raw_request_view = hw_request | soft_request_word_r;
    assign fast_class_status = raw_request_view & enable_r & class_select_r;
    assign normal_class_status = raw_request_view & enable_r & ~class_select_r;

    // Fast requests bypass the vector logic entirely; normal_irq_out stays driven while the fast line is up.
    assign fast_irq_out = |fast_class_status;
    assign normal_irq_out = |normal_class_status;

    // ****************************************************************
    // Vector slots
    // ****************************************************************
    wire [NUM_SLOT-1:0] slot_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOT; gi = gi + 1) begin : g_slot
            wire [`VIU_CTL_SRC_HI:`VIU_CTL_SRC_LO] src;
            assign src = slot_ctl_r[gi][`VIU_CTL_SRC_HI:`VIU_CTL_SRC_LO];
            // A slot only fires for a normal-class source, so a fast-class source never vectors.
            assign slot_hit[gi] = slot_ctl_r[gi][`VIU_CTL_INUSE] & normal_class_status[src];
        end
    endgenerate

    // Lowest slot number wins; the scan runs downward so slot 0 is assigned last.
    reg [31:0] active_vector_word;
    integer si;
    always @* begin
        active_vector_word = default_vector_word_r;
        for (si = NUM_SLOT - 1; si >= 0; si = si - 1) begin
            if (slot_hit[si]) begin
                active_vector_word = slot_addr_r[si];
            end
        end
    end

    // ****************************************************************
    // Event flags and interrupt line
    // ****************************************************************
    wire [`VIU_EV_W-1:0] event_set;
    wire [`VIU_EV_W-1:0] event_clr;
    wire priv_fault;

    assign irq_out = |(event_status_r & event_mask_r);

    // ****************************************************************
    // Write path
    // ****************************************************************
    wire [3:0] w_page;
    wire [3:0] w_slot;
    wire w_slot_ok;
    wire w_exec;
    wire w_full;
    wire w_allowed;
    reg w_mapped;

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    assign w_page = aw_addr_r[`VIU_PAGE_HI:`VIU_PAGE_LO];
    assign w_slot = aw_addr_r[`VIU_SLOT_HI:`VIU_SLOT_LO];
    assign w_slot_ok = (aw_addr_r[`VIU_SLOT_PAD_HI:`VIU_SLOT_PAD_LO] == 2'h0) &
                       (aw_addr_r[`VIU_WORD_LO_HI:0] == 2'h0);
    assign w_exec = aw_held_r & w_held_r & ~bvalid_r;
    assign w_full = (w_strb_r == `VIU_STRB_FULL);
    assign w_allowed = w_full & (~privileged_only_flag_r | aw_priv_r);

    always @* begin
        case (aw_addr_r)
            `VIU_OFF_CLASS_SELECT, `VIU_OFF_ENABLE_SET, `VIU_OFF_ENABLE_CLEAR,
            `VIU_OFF_SOFT_REQUEST, `VIU_OFF_SOFT_CLEAR, `VIU_OFF_PRIV_ONLY,
            `VIU_OFF_ACTIVE_VECTOR, `VIU_OFF_DEFAULT_VECTOR,
            `VIU_OFF_EVENT_STATUS, `VIU_OFF_EVENT_MASK: w_mapped = 1'b1;
            default: w_mapped = w_slot_ok &
                ((w_page == `VIU_PAGE_SLOT_ADDR) | (w_page == `VIU_PAGE_SLOT_CTRL));
        endcase
    end

    wire w_do;
    assign w_do = w_exec & w_allowed & w_mapped;

    integer wi;
    always @(posedge clk) begin
        if (!rstn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= {ADDR_W{1'b0}};
            aw_priv_r <= 1'b0;
            w_held_r <= 1'b0;
            w_data_r <= `VIU_RST_WORD;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `VIU_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
                aw_priv_r <= s_axi_awprot[0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (w_exec) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (w_allowed && w_mapped) ? `VIU_RESP_OKAY : `VIU_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Register updates
    // ****************************************************************
    always @(posedge clk) begin
        if (!rstn) begin
            class_select_r <= {NUM_REQ{1'b0}};
            enable_r <= {NUM_REQ{1'b0}};
            soft_request_word_r <= {NUM_REQ{1'b0}};
            privileged_only_flag_r <= 1'b0;
            default_vector_word_r <= `VIU_RST_WORD;
            event_mask_r <= `VIU_RST_EV;
            for (wi = 0; wi < NUM_SLOT; wi = wi + 1) begin
                slot_addr_r[wi] <= `VIU_RST_WORD;
                slot_ctl_r[wi] <= `VIU_RST_CTL;
            end
        end else if (w_do) begin
            case (aw_addr_r)
                `VIU_OFF_CLASS_SELECT: class_select_r <= w_data_r[NUM_REQ-1:0];
                `VIU_OFF_ENABLE_SET: enable_r <= enable_r | w_data_r[NUM_REQ-1:0];
                `VIU_OFF_ENABLE_CLEAR: enable_r <= enable_r & ~w_data_r[NUM_REQ-1:0];
                `VIU_OFF_SOFT_REQUEST: begin
                    soft_request_word_r <= soft_request_word_r | w_data_r[NUM_REQ-1:0];
                end
                `VIU_OFF_SOFT_CLEAR: begin
                    soft_request_word_r <= soft_request_word_r & ~w_data_r[NUM_REQ-1:0];
                end
                `VIU_OFF_PRIV_ONLY: privileged_only_flag_r <= w_data_r[0];
                `VIU_OFF_DEFAULT_VECTOR: default_vector_word_r <= w_data_r;
                `VIU_OFF_EVENT_MASK: event_mask_r <= w_data_r[`VIU_EV_W-1:0];
                default: begin
                    if (w_page == `VIU_PAGE_SLOT_ADDR) begin
                        slot_addr_r[w_slot] <= w_data_r;
                    end else if (w_page == `VIU_PAGE_SLOT_CTRL) begin
                        slot_ctl_r[w_slot] <= w_data_r[`VIU_CTL_W-1:0];
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Event capture
    // ****************************************************************
    assign event_set[`VIU_EV_FAST] = fast_irq_out & ~fast_prev_r;
    assign event_set[`VIU_EV_NORMAL] = normal_irq_out & ~normal_prev_r;
    assign event_set[`VIU_EV_PRIV] = priv_fault;
    assign event_clr = (w_do && aw_addr_r == `VIU_OFF_EVENT_STATUS) ?
                       w_data_r[`VIU_EV_W-1:0] : `VIU_RST_EV;

    // A set in the same cycle as its clear survives, so no edge is ever lost.
    always @(posedge clk) begin
        if (!rstn) begin
            event_status_r <= `VIU_RST_EV;
            fast_prev_r <= 1'b0;
            normal_prev_r <= 1'b0;
        end else begin
            event_status_r <= (event_status_r & ~event_clr) | event_set;
            fast_prev_r <= fast_irq_out;
            normal_prev_r <= normal_irq_out;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire [3:0] r_page;
    wire [3:0] r_slot;
    wire r_slot_ok;
    wire r_take;
    wire r_allowed;
    reg [31:0] r_word;
    reg r_mapped;

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign r_take = s_axi_arvalid & ~rvalid_r;
    assign r_page = s_axi_araddr[`VIU_PAGE_HI:`VIU_PAGE_LO];
    assign r_slot = s_axi_araddr[`VIU_SLOT_HI:`VIU_SLOT_LO];
    assign r_slot_ok = (s_axi_araddr[`VIU_SLOT_PAD_HI:`VIU_SLOT_PAD_LO] == 2'h0) &
                       (s_axi_araddr[`VIU_WORD_LO_HI:0] == 2'h0);
    assign r_allowed = ~privileged_only_flag_r | s_axi_arprot[0];

    // A refused or partial write, or an unprivileged read under protection, is flagged.
    assign priv_fault = (w_exec & ~w_allowed) | (r_take & ~r_allowed);

    always @* begin
        r_word = `VIU_RST_WORD;
        r_mapped = 1'b1;
        case (s_axi_araddr)
            `VIU_OFF_NORMAL_STATUS: r_word = normal_class_status;
            `VIU_OFF_FAST_STATUS: r_word = fast_class_status;
            `VIU_OFF_RAW_VIEW: r_word = raw_request_view;
            `VIU_OFF_CLASS_SELECT: r_word = class_select_r;
            `VIU_OFF_ENABLE_SET: r_word = enable_r;
            `VIU_OFF_SOFT_REQUEST: r_word = soft_request_word_r;
            `VIU_OFF_PRIV_ONLY: r_word[0] = privileged_only_flag_r;
            `VIU_OFF_ACTIVE_VECTOR: r_word = active_vector_word;
            `VIU_OFF_DEFAULT_VECTOR: r_word = default_vector_word_r;
            `VIU_OFF_EVENT_STATUS: r_word[`VIU_EV_W-1:0] = event_status_r;
            `VIU_OFF_EVENT_MASK: r_word[`VIU_EV_W-1:0] = event_mask_r;
            default: begin
                if (r_slot_ok && r_page == `VIU_PAGE_SLOT_ADDR) begin
                    r_word = slot_addr_r[r_slot];
                end else if (r_slot_ok && r_page == `VIU_PAGE_SLOT_CTRL) begin
                    r_word[`VIU_CTL_W-1:0] = slot_ctl_r[r_slot];
                end else begin
                    r_mapped = 1'b0;
                end
            end
        endcase
    end

    // Clear-only locations have no read value and answer as unmapped.
    always @(posedge clk) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rdata_r <= `VIU_RST_WORD;
            rresp_r <= `VIU_RESP_OKAY;
        end else if (r_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= (r_allowed && r_mapped) ? r_word : `VIU_RST_WORD;
            rresp_r <= (r_allowed && r_mapped) ? `VIU_RESP_OKAY : `VIU_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule // viu_vectored_irq_unit

// ==== dv/viu_props.sv ====
// Bus handshake checker for the vectored interrupt unit.
`timescale 1ns/1ps
`include "vecirq_map.vh"
module viu_props #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Write channels
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [3:0] s_axi_wstrb,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Read channels
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_answer;
        s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    property p_wr_busy;
        s_wr_take |=> (!s_axi_awready && !s_axi_wready) [*2];
    endproperty
    property p_rd_answer;
        s_rd_take |=> s_axi_rvalid;
    endproperty
    property p_strb_err;
        s_wr_take ##0 (s_axi_wstrb != `VIU_STRB_FULL)
            |=> ##1 (s_axi_bvalid && s_axi_bresp == `VIU_RESP_SLVERR);
    endproperty
    property p_wo_read;
        s_rd_take ##0 (s_axi_araddr == `VIU_OFF_ENABLE_CLEAR ||
                       s_axi_araddr == `VIU_OFF_SOFT_CLEAR)
            |=> s_axi_rresp == `VIU_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_ar_ready;
        s_axi_arready == !s_axi_rvalid;
    endproperty
    property p_b_blocks;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_b_one;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_r_one;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("late write answer");
    a_wr_busy: assert property (p_wr_busy) else $error("write ready too early");
    a_rd_answer: assert property (p_rd_answer) else $error("late read answer");
    a_strb_err: assert property (p_strb_err) else $error("partial write accepted");
    a_wo_read: assert property (p_wo_read) else $error("write-only word read");
    a_ar_ready: assert property (p_ar_ready) else $error("arready mismatch");
    a_b_blocks: assert property (p_b_blocks) else $error("write taken in answer");
    a_b_one: assert property (p_b_one) else $error("bvalid repeated");
    a_r_one: assert property (p_r_one) else $error("rvalid repeated");
endmodule // viu_props

bind viu_vectored_irq_unit viu_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ==== dv/viu_core_model.sv ====
// Behavioural core that takes the fast and normal interrupt lines of the unit.
`timescale 1ns/1ps
module viu_core_model (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Interrupt lines
    input wire fast_irq_out,
    input wire normal_irq_out,
    // Handler entries seen
    output reg [7:0] fast_cnt_r,
    output reg [7:0] normal_cnt_r
);
    reg fast_r;
    reg normal_r;
    // A normal entry is held off while the fast line is up, as a core would.
    always @(posedge clk) begin
        if (!rstn) begin
            {fast_r, normal_r, fast_cnt_r, normal_cnt_r} <= 18'h00000;
        end else begin
            fast_r <= fast_irq_out;
            normal_r <= normal_irq_out && !fast_irq_out;
            if (fast_irq_out && !fast_r) begin
                fast_cnt_r <= fast_cnt_r + 8'h01;
            end
            if (normal_irq_out && !fast_irq_out && !normal_r) begin
                normal_cnt_r <= normal_cnt_r + 8'h01;
            end
        end
    end
endmodule // viu_core_model

// ==== dv/tb_vectored_interrupt_ctrl.sv ====
// Self-checking testbench of the vectored interrupt unit.
`timescale 1ns/1ps
`include "vecirq_map.vh"
module tb_vectored_interrupt_ctrl;
    logic clk = 0;
    logic rstn = 0;
    logic [31:0] hw_request = 32'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h1;
    logic [2:0] s_axi_arprot = 3'h1;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0;
    logic s_axi_wvalid = 0;
    logic s_axi_arvalid = 0;
    logic s_axi_bready = 1;
    logic s_axi_rready = 1;
    wire fast_irq_out, normal_irq_out, irq_out, s_axi_awready, s_axi_wready;
    wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] fast_cnt_r, normal_cnt_r;
    int failures = 0;
    int checked = 0;
    logic [31:0] lfsr_r = 32'hE7BB;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [31:0] va[16];
    logic [31:0] x, y, z;
    always #50 clk = ~clk;
    viu_vectored_irq_unit u_dut (.*);
    viu_core_model u_core (.*);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction
    task automatic end_of_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic note(input bit ok, input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (!ok) begin
            failures++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic cmp_rd(input logic [33:0] e, input logic [33:0] g);
        note(g === e, e, g);
    endtask
    task automatic cmp_wr(input logic [1:0] e, input logic [1:0] g);
        note(g === e, {32'h0, e}, {32'h0, g});
    endtask
    task automatic cmp_lvl(input logic e, input logic g);
        note(g === e, {33'h0, e}, {33'h0, g});
    endtask
    // A wait that runs out ends the run as a failure.
    task automatic guard(input int n);
        if (n >= 50) begin
            note(0, 34'h0, 34'(n));
            end_of_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                      input logic [2:0] p = 3'h1, input logic [1:0] r = 2'h0);
        logic ta;
        logic tw;
        int n;
        bq.push_back(r);
        ta = 0;
        tw = 0;
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid} <= {a, p, 1'b1};
        {s_axi_wdata, s_axi_wstrb, s_axi_wvalid} <= {d, s, 1'b1};
        for (n = 0; n < 50 && !(ta && tw); n++) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                ta = 1;
                s_axi_awvalid <= 0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                tw = 1;
                s_axi_wvalid <= 0;
            end
        end
        guard(n);
        for (n = 0; n < 50 && !s_axi_bvalid; n++) @(posedge clk);
        guard(n);
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e, input logic [2:0] p = 3'h1);
        int n;
        rq.push_back(e);
        {s_axi_araddr, s_axi_arprot, s_axi_arvalid} <= {a, p, 1'b1};
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (s_axi_arready) break;
        end
        guard(n);
        s_axi_arvalid <= 0;
        for (n = 0; n < 50 && !s_axi_rvalid; n++) @(posedge clk);
        guard(n);
    endtask
    always @(posedge clk) begin
        if (rstn && s_axi_rvalid && s_axi_rready) begin
            cmp_rd(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (rstn && s_axi_bvalid && s_axi_bready) begin
            cmp_wr(bq.pop_front(), s_axi_bresp);
        end
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        int i;
        logic [11:0] a;
        repeat (20) @(posedge clk);
        rstn <= 1;
        // Holes and write-only words answer with an error and zero data.
        for (i = 0; i < 18; i++) begin
            a = 12'(i * 4);
            rd(a, (a == 12'h014 || a == 12'h01C || (a > 12'h020 && a < 12'h030) || a > 12'h034
                   && a < 12'h040) ? {2'h2, 32'h0} : 34'h0);
        end
        wr(12'h024, 32'h1, 4'hF, 3'h1, 2'h2);
        $display("test map done");
        x = rnd();
        y = rnd();
        z = rnd();
        hw_request <= x;
        wr(12'h018, y);
        wr(12'h010, z);
        wr(12'h00C, x ^ y);
        rd(12'h008, x | y);
        rd(12'h000, (x | y) & z & ~(x ^ y));
        rd(12'h004, (x | y) & z & (x ^ y));
        @(negedge clk);
        cmp_lvl(|((x | y) & z & (x ^ y)), fast_irq_out);
        cmp_lvl(|((x | y) & z & ~(x ^ y)), normal_irq_out);
        @(posedge clk);
        wr(12'h014, y);
        rd(12'h010, z & ~y);
        $display("test classes done");
        hw_request <= 32'h0;
        wr(12'h01C, 32'hFFFF_FFFF);
        wr(12'h010, 32'hFFFF_FFFF);
        wr(12'h00C, 32'h0);
        x = rnd();
        wr(12'h034, x);
        // Slot 0 names source 11 but is left unused; slot 3 owns it.
        for (i = 0; i < 16; i++) begin
            va[i] = rnd();
            wr(12'h100 + 12'(i * 4), va[i]);
            wr(12'h200 + 12'(i * 4), (i == 0) ? 32'h0B : 32'h20 | (i + 8));
        end
        rd(12'h030, x);
        wr(12'h030, 32'h0);
        rd(12'h030, x);
        wr(12'h018, 32'h0002_0800);
        rd(12'h030, va[3]);
        wr(12'h00C, 32'h0000_0800);
        rd(12'h030, va[9]);
        @(negedge clk);
        cmp_lvl(1'b1, fast_irq_out);
        @(posedge clk);
        wr(12'h01C, 32'hFFFF_FFFF);
        wr(12'h018, 32'h4000_0000);
        rd(12'h030, x);
        @(negedge clk);
        cmp_lvl(1'b1, normal_irq_out);
        @(posedge clk);
        $display("test vectors done");
        wr(12'h040, 32'h7);
        wr(12'h044, 32'h4);
        wr(12'h018, 32'h1, 4'h3, 3'h1, 2'h2);
        @(negedge clk);
        cmp_lvl(1'b1, irq_out);
        @(posedge clk);
        wr(12'h040, 32'h4);
        @(negedge clk);
        cmp_lvl(1'b0, irq_out);
        @(posedge clk);
        wr(12'h020, 32'h1);
        rd(12'h000, {2'h2, 32'h0}, 3'h0);
        wr(12'h018, 32'h1, 4'hF, 3'h0, 2'h2);
        rd(12'h018, 34'h4000_0000);
        wr(12'h020, 32'h0);
        rd(12'h020, 34'h0, 3'h0);
        @(negedge clk);
        cmp_lvl(1'b1, irq_out);
        cmp_lvl(1'b1, fast_cnt_r != 8'h00 && normal_cnt_r != 8'h00);
        $display("test refusals done");
        end_of_test();
    end
endmodule // tb_vectored_interrupt_ctrl
